// file: rtl/gpb_pkg.sv
// package of register map, bit layout and reset values for the pin bank
// assumes byte-wide i/o-space accesses with a 16-bit port address
package gpb_pkg;
    localparam int          GPB_LINES        = 8;
    localparam logic [15:0] GPB_BASE         = 16'h0500;
    localparam logic [7:0]  GPB_OFS_FUNC_LO  = 8'h00;
    localparam logic [7:0]  GPB_OFS_DIR_LO   = 8'h04;
    localparam logic [7:0]  GPB_OFS_LVL_LO   = 8'h0C;
    localparam logic [7:0]  GPB_OFS_INV      = 8'h2C;
    localparam logic [7:0]  GPB_OFS_FUNC_HI  = 8'h30;
    localparam logic [7:0]  GPB_OFS_DIR_HI   = 8'h34;
    localparam logic [7:0]  GPB_OFS_LVL_HI   = 8'h38;
    localparam logic [15:0] GPB_WIN_MASK     = 16'hFFC0;
    localparam logic [7:0]  GPB_LO_BITS      = 8'h3C;
    localparam logic [7:0]  GPB_HI_BITS      = 8'hC6;
    localparam int          GPB_LO_SHIFT     = 2;
    localparam logic [7:0]  GPB_FUNC_RST     = 8'hFF;
    localparam logic [7:0]  GPB_DIR_RST      = 8'h0F;
    localparam logic [7:0]  GPB_INV_RST      = 8'h00;
    localparam logic [7:0]  GPB_INV_LINES    = 8'h0F;
    typedef enum logic [2:0] {
        GPB_R_NONE,
        GPB_R_FUNC,
        GPB_R_DIR,
        GPB_R_LVL,
        GPB_R_INV
    } gpb_reg_t;
endpackage

// file: rtl/gpb_sync.sv
// two-stage synchroniser for the eight pin inputs
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
module gpb_sync
    import gpb_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic [GPB_LINES-1:0] pin_async,
    output logic      [GPB_LINES-1:0] pin_sync
);
    logic [GPB_LINES-1:0] stage1;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            stage1   <= '0;
            pin_sync <= '0;
        end
        else
        begin
            stage1   <= pin_async;
            pin_sync <= stage1;
        end
    end
endmodule

// file: rtl/gpb_lane_map.sv
// maps bank register bits onto eight line-ordered vectors and back
// pure combinational, used for both banks
`timescale 1ns/1ps
module gpb_lane_map
    import gpb_pkg::*;
(
    input  wire logic [7:0]           lo_byte,
    input  wire logic [7:0]           hi_byte,
    input  wire logic [GPB_LINES-1:0] lines_in,
    output logic      [GPB_LINES-1:0] lines_out,
    output logic      [7:0]           lo_view,
    output logic      [7:0]           hi_view
);
    // lines 0..3 on bits 2..5; lines 4..7 on bits 1,2,6,7
    assign lines_out = {hi_byte[7], hi_byte[6], hi_byte[2], hi_byte[1],
                        lo_byte[5:2]};
    assign lo_view = {2'b00, lines_in[3:0], 2'b00};
    assign hi_view = {lines_in[7], lines_in[6], 3'b000,
                      lines_in[5], lines_in[4], 1'b0};
endmodule

// file: rtl/gpb_bank.sv
// eight-line general-purpose pin bank with byte i/o register access
// assumes one i/o strobe per access, data sampled on the strobe cycle
//
// Contract
// - registers decoded in i/o space at base 0x500
// - function bit zero native, one general-purpose
// - direction bit zero output, one input
// - output pins driven from level register bits
// - input lines read sampled pin state
// - polarity bit one inverts reported input
// - inversion only on the four lower lines
// - lower lines occupy bits two to five
// - clearing level bit five drives line three low
// - output reset level is a parameter
`timescale 1ns/1ps
module gpb_bank
    import gpb_pkg::*;
#(
    parameter logic OUT_RESET_LEVEL = 1'b0
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic [15:0]          io_addr,
    input  wire logic                 io_wr,
    input  wire logic                 io_rd,
    input  wire logic [7:0]           io_wdata,
    output logic      [7:0]           io_rdata,
    output logic                      io_ack,
    input  wire logic [GPB_LINES-1:0] pin_in,
    output logic      [GPB_LINES-1:0] pin_out,
    output logic      [GPB_LINES-1:0] pin_oe_n,
    output logic      [GPB_LINES-1:0] native_sel,
    input  wire logic [GPB_LINES-1:0] native_out,
    input  wire logic [GPB_LINES-1:0] native_oe_n,
    output logic      [GPB_LINES-1:0] native_in
);
    ////////////////////////////////////////////////////////////////////////
    // address decode
    function automatic gpb_reg_t reg_of(input logic [7:0] ofs);
        case (ofs)
            GPB_OFS_FUNC_LO, GPB_OFS_FUNC_HI: reg_of = GPB_R_FUNC;
            GPB_OFS_DIR_LO,  GPB_OFS_DIR_HI:  reg_of = GPB_R_DIR;
            GPB_OFS_LVL_LO,  GPB_OFS_LVL_HI:  reg_of = GPB_R_LVL;
            GPB_OFS_INV:                      reg_of = GPB_R_INV;
            default:                          reg_of = GPB_R_NONE;
        endcase
    endfunction

    function automatic logic is_hi(input logic [7:0] ofs);
        is_hi = (ofs == GPB_OFS_FUNC_HI) || (ofs == GPB_OFS_DIR_HI)
             || (ofs == GPB_OFS_LVL_HI);
    endfunction

    localparam logic [GPB_LINES-1:0] LVL_RST = {GPB_LINES{OUT_RESET_LEVEL}};

    wire logic       in_win   = (io_addr & GPB_WIN_MASK)
                                == GPB_BASE;
    wire logic [7:0] ofs      = io_addr[7:0] - GPB_BASE[7:0];
    wire gpb_reg_t   sel      = in_win ? reg_of(ofs) : GPB_R_NONE;
    wire logic       sel_hi   = is_hi(ofs);
    wire logic       wr_hit   = io_wr && (sel != GPB_R_NONE);
    wire logic       rd_hit   = io_rd && (sel != GPB_R_NONE);

    ////////////////////////////////////////////////////////////////////////
    // storage in line order
    logic [GPB_LINES-1:0] func_q;
    logic [GPB_LINES-1:0] dir_q;
    logic [GPB_LINES-1:0] lvl_q;
    logic [GPB_LINES-1:0] inv_q;
    logic [GPB_LINES-1:0] pin_s;

    gpb_sync u_sync (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .pin_async (pin_in),
        .pin_sync  (pin_s)
    );

    // write data mapped to lines, with lane choice by bank
    logic [GPB_LINES-1:0] wr_lines;
    gpb_lane_map u_wmap (
        .lo_byte   (io_wdata),
        .hi_byte   (io_wdata),
        .lines_in  ('0),
        .lines_out (wr_lines),
        .lo_view   (),
        .hi_view   ()
    );

    wire logic [GPB_LINES-1:0] bank_mask = sel_hi ? 8'hF0 : 8'h0F;

    function automatic logic [GPB_LINES-1:0] merge(
        input logic [GPB_LINES-1:0] old_v,
        input logic [GPB_LINES-1:0] new_v,
        input logic [GPB_LINES-1:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    wire logic [GPB_LINES-1:0] next_func = merge(func_q, wr_lines, bank_mask);
    wire logic [GPB_LINES-1:0] next_dir  = merge(dir_q, wr_lines, bank_mask);
    wire logic [GPB_LINES-1:0] next_lvl  = merge(lvl_q, wr_lines, bank_mask);
    wire logic [GPB_LINES-1:0] next_inv  = wr_lines & GPB_INV_LINES;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            func_q <= GPB_FUNC_RST;
            dir_q  <= GPB_DIR_RST;
            lvl_q  <= LVL_RST;
            inv_q  <= GPB_INV_RST;
        end
        else if (wr_hit)
        begin
            case (sel)
                GPB_R_FUNC: func_q <= next_func;
                GPB_R_DIR:  dir_q  <= next_dir;
                GPB_R_LVL:  lvl_q  <= next_lvl;
                GPB_R_INV:  inv_q  <= next_inv;
                default:    func_q <= func_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback
    wire logic [GPB_LINES-1:0] inv_lo   = inv_q & GPB_INV_LINES;
    wire logic [GPB_LINES-1:0] in_view  = pin_s ^ inv_lo;
    wire logic [GPB_LINES-1:0] lvl_view = (dir_q & in_view)
                                        | (~dir_q & lvl_q);

    logic [GPB_LINES-1:0] rd_lines;
    always_comb
    begin
        case (sel)
            GPB_R_FUNC: rd_lines = func_q;
            GPB_R_DIR:  rd_lines = dir_q;
            GPB_R_LVL:  rd_lines = lvl_view;
            GPB_R_INV:  rd_lines = inv_q;
            default:    rd_lines = '0;
        endcase
    end

    logic [7:0] rd_lo;
    logic [7:0] rd_hi;
    gpb_lane_map u_rmap (
        .lo_byte   (8'h00),
        .hi_byte   (8'h00),
        .lines_in  (rd_lines),
        .lines_out (),
        .lo_view   (rd_lo),
        .hi_view   (rd_hi)
    );

    // inversion register has lower lanes only
    wire logic [7:0] next_rdata = !rd_hit ? 8'h00
                                : (sel_hi ? rd_hi : rd_lo);

    ////////////////////////////////////////////////////////////////////////
    // pin drive: general-purpose or native path
    wire logic [GPB_LINES-1:0] next_out  = (func_q & lvl_q)
                                         | (~func_q & native_out);
    wire logic [GPB_LINES-1:0] next_oe_n = (func_q & dir_q)
                                         | (~func_q & native_oe_n);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            io_rdata   <= 8'h00;
            io_ack     <= 1'b0;
            pin_out    <= LVL_RST;
            pin_oe_n   <= GPB_DIR_RST;
            native_sel <= ~GPB_FUNC_RST;
            native_in  <= '0;
        end
        else
        begin
            io_rdata   <= next_rdata;
            io_ack     <= wr_hit || rd_hit;
            pin_out    <= next_out;
            pin_oe_n   <= next_oe_n;
            native_sel <= ~func_q;
            native_in  <= pin_s & ~func_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_lvl_write(int b);
        io_wr && in_win && ofs == GPB_OFS_LVL_LO && !io_wdata[b];
    endsequence

    // line three under general-purpose control and driving its pin
    sequence s_line3_out;
        func_q[3] && !dir_q[3];
    endsequence

    a_base_decode: assert property (
        io_wr && !in_win |=> !io_ack)
        else $error("access outside base acknowledged");

    a_line3_low: assert property (
        s_lvl_write(5) ##0 s_line3_out |=> ##1 !pin_out[3])
        else $error("line three not driven low");

    a_dir_input: assert property (
        func_q[2] && dir_q[2] |=> pin_oe_n[2])
        else $error("input line still driven");

    a_out_follow: assert property (
        func_q[5] && !dir_q[5] |=> pin_out[5] == $past(lvl_q[5]))
        else $error("output line not following level");

    a_native_route: assert property (
        !func_q[0] |=> native_sel[0] && pin_out[0] == $past(native_out[0]))
        else $error("native line not routed");

    a_in_read: assert property (
        io_rd && in_win && ofs == GPB_OFS_LVL_LO && dir_q[1]
        |=> io_rdata[3] == $past(pin_s[1] ^ inv_q[1]))
        else $error("input level readback wrong");

    a_no_hi_inv: assert property (
        inv_q[7:4] == 4'h0)
        else $error("upper line inversion set");

    a_hi_zero: assert property (
        io_rd && in_win && sel_hi |=> (io_rdata & ~GPB_HI_BITS) == 8'h00)
        else $error("unused upper bank bits nonzero");

    a_lo_zero: assert property (
        io_rd && in_win && !sel_hi |=> (io_rdata & ~GPB_LO_BITS) == 8'h00)
        else $error("unused lower bank bits nonzero");

    a_reset_cfg: assert property (disable iff (1'b0)
        !nrst |=> func_q == GPB_FUNC_RST && dir_q == GPB_DIR_RST)
        else $error("reset configuration wrong");
endmodule

// file: tb/gpio_port_bank_test.sv
// self-checking bench for the eight-line pin bank
// assumes gpb_bank with default output reset level 0
`timescale 1ns/1ps
module gpio_port_bank_test;
    import gpb_pkg::*;
    logic        ref_clk, nrst, io_wr, io_rd, io_ack;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata, pin_in, pin_out, pin_oe_n;
    logic [7:0]  native_sel, native_out, native_oe_n, native_in;
    logic [7:0]  exp_q[$];
    int          err_count, checked, i;
    logic [7:0]  v, p;

    gpb_bank dut_u (.ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_ack(io_ack), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .native_sel(native_sel),
        .native_out(native_out), .native_oe_n(native_oe_n),
        .native_in(native_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string s);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task finish_test;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one strobe cycle, then a quiet cycle before the next access
    task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_wr = w;
        io_rd = !w;
        io_wdata = d;
        @(negedge ref_clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask

    task wr(input logic [7:0] ofs, input logic [7:0] d);
        exp_q.push_back(8'h00);
        acc(1'b1, GPB_BASE + {8'h00, ofs}, d);
    endtask

    task rd(input logic [7:0] ofs, input logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, GPB_BASE + {8'h00, ofs}, 8'h00);
    endtask

    task settle;
        repeat (2) @(negedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // response watcher: every ack takes the oldest note
    always @(negedge ref_clk)
        if (io_ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(8'hFF, 8'h00, "unexpected ack");
            else
                check(io_rdata, exp_q.pop_front(), "read data");
        end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("MISMATCH t=%0t run timed out", $time);
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {nrst, io_wr, io_rd, io_addr, io_wdata, pin_in, native_out} = '0;
        native_oe_n = 8'hFF;
        err_count = 0;
        checked = 0;
        v = $urandom(81);
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        rd(GPB_OFS_FUNC_LO, 8'h3C);
        rd(GPB_OFS_DIR_LO, 8'h3C);
        rd(GPB_OFS_FUNC_HI, 8'hC6);
        rd(GPB_OFS_DIR_HI, 8'h00);
        rd(GPB_OFS_INV, 8'h00);
        rd(GPB_OFS_LVL_HI, 8'h00);
        check(pin_oe_n, 8'h0F, "reset drive");
        check(pin_out, 8'h00, "reset level");
        $display("test reset done");
        p = $urandom;
        pin_in = p;
        repeat (4) @(negedge ref_clk);
        rd(GPB_OFS_LVL_LO, {2'b00, p[3:0], 2'b00});
        wr(GPB_OFS_INV, 8'hFF);
        rd(GPB_OFS_INV, 8'h3C);
        rd(GPB_OFS_LVL_LO, {2'b00, ~p[3:0], 2'b00});
        wr(GPB_OFS_DIR_HI, 8'hFF);
        rd(GPB_OFS_DIR_HI, 8'hC6);
        rd(GPB_OFS_LVL_HI, {p[7:6], 3'b000, p[5:4], 1'b0});
        wr(GPB_OFS_INV, 8'h00);
        $display("test inputs done");
        wr(GPB_OFS_DIR_LO, 8'h00);
        wr(GPB_OFS_LVL_LO, 8'hFF);
        settle();
        check({4'h0, pin_out[3:0]}, 8'h0F, "low out");
        check({4'h0, pin_oe_n[3:0]}, 8'h00, "low drive");
        rd(GPB_OFS_LVL_LO, 8'h3C);
        wr(GPB_OFS_LVL_LO, 8'h3C & 8'hDF);
        settle();
        check({4'h0, pin_out[3:0]}, 8'h07, "line3 low");
        rd(GPB_OFS_DIR_LO, 8'h00);
        wr(GPB_OFS_DIR_LO, 8'h10);
        settle();
        check({4'h0, pin_oe_n[3:0]}, 8'h04, "line2 in");
        wr(GPB_OFS_DIR_HI, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            v = $urandom;
            wr(GPB_OFS_LVL_HI, v);
            settle();
            check(pin_out & 8'hF0, {v[7:6], v[2:1], 4'h0}, "hi out");
            rd(GPB_OFS_LVL_HI, v & 8'hC6);
        end
        check({pin_oe_n[7:4], 4'h0}, 8'h00, "hi drive");
        $display("test outputs done");
        native_out = $urandom;
        native_oe_n = $urandom;
        wr(GPB_OFS_FUNC_LO, 8'h00);
        wr(GPB_OFS_FUNC_HI, 8'h00);
        repeat (5) @(negedge ref_clk);
        check(native_sel, 8'hFF, "native sel");
        check(pin_out, native_out, "native out");
        check(pin_oe_n, native_oe_n, "native drive");
        check(native_in, p, "native in");
        wr(GPB_OFS_FUNC_LO, 8'h3C);
        settle();
        check(native_sel, 8'hF0, "gp sel");
        check(native_in, {p[7:4], 4'h0}, "gp native in");
        $display("test native done");
        acc(1'b0, 16'h0540, 8'h00);
        acc(1'b1, 16'h04FC, 8'hFF);
        acc(1'b0, 16'h0508, 8'h00);
        for (i = 0; i < 20 && exp_q.size() != 0; i++)
            @(negedge ref_clk);
        repeat (3) @(negedge ref_clk);
        check(8'(exp_q.size()), 8'h00, "notes left");
        $display("test unmapped done");
        finish_test();
    end
endmodule
